// ==== core/twcs_slave.sv ====
`include "twcs_consts.svh"
// Functional notes
// RULE1: low select pin picks two-wire, high disables it
// RULE2: start is sda falling while sclk high
// RULE3: after start shift eight bits msb first
// RULE4: matching address acknowledged by holding sda low
// RULE5: address mismatch idles until next start
// RULE6: write is index, upper byte, lower byte
// RULE7: stop ends transfer and returns to idle
// RULE8: stray start or stop abandons the transfer
// RULE9: address 34h pin low, 36h pin high
// RULE10: auto-increment writes consecutive registers after index
// RULE11: master reads via index write then repeated start
// RULE12: on read address ack, transmit register msb first
// RULE13: master acks first byte, not the last
// RULE14: every register readable over the data line
// RULE15: auto-increment read walks increasing indices until stop
// RULE16: control data handed over resynchronised to core clock
// RULE17: release sda when idle, change only sclk low
`timescale 1ns/1ps
`default_nettype none

module twcs_slave
    import twcs_pkg::*;
#(
    parameter int          AW       = `TWCS_INDEX_W,
    parameter int          DW       = `TWCS_DATA_W,
    parameter logic [15:0] ID_VALUE = `TWCS_ID_VALUE   // arbitrary identity word
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          interface_select_pin,
    input  wire logic          addr_select_pin,
    input  wire logic          auto_inc_en,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe_b,
    output logic               reg_wr_valid,
    output logic      [AW-1:0] reg_wr_index,
    output logic      [DW-1:0] reg_wr_data
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic [4:0]    sync_s;      // synchronised pins
    logic          scl_s;       // synchronised clock line
    logic          sda_s;       // synchronised data line
    logic          sel_s;       // interface select, high means three-wire
    logic          asel_s;      // address select
    logic          auto_s;      // auto-increment enable
    logic          scl_d_r;     // previous scl sample
    logic          sda_d_r;     // previous sda sample
    logic          scl_rise;
    logic          scl_fall;
    logic          start_ev;
    logic          stop_ev;

    // every outside level passes two flops before any logic sees it
    twcs_sync #(.W(5)) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in ({auto_inc_en, addr_select_pin, interface_select_pin, sda_i, scl_i}),
        .sync_out (sync_s)
    );

    assign scl_s  = sync_s[0];
    assign sda_s  = sync_s[1];
    assign sel_s  = sync_s[2];
    assign asel_s = sync_s[3];
    assign auto_s = sync_s[4];

    // delayed copies for edge finding, reset high like an idle bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    // sda moving with sclk held high in both samples
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;   // see RULE2
    assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;   // see RULE7

    // own bus address from the select pin
    function automatic logic [6:0] twcs_own_addr(input logic sel);
        twcs_own_addr = sel ? `TWCS_ADDR_SEL1 : `TWCS_ADDR_SEL0;   // see RULE9
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link sequencer

    twcs_state_t   state_r, state_nxt;
    twcs_phase_t   phase_r, phase_nxt;     // byte position in a write
    logic [3:0]    bitcnt_r, bitcnt_nxt;   // bits seen in the current byte
    logic [7:0]    shift_r, shift_nxt;     // receive or transmit shifter
    logic          is_addr_r, is_addr_nxt; // current byte is the address
    logic          rw_r, rw_nxt;           // read bit of last matched address
    logic [AW-1:0] index_r, index_nxt;     // register pointer
    logic [7:0]    hi_r, hi_nxt;           // held upper data byte
    logic          tx_lo_r, tx_lo_nxt;     // transmitting the lower byte
    logic          mack_r, mack_nxt;       // master acknowledged
    logic          sda_drv_r, sda_drv_nxt; // pulling sda low
    logic          wr_valid_r, wr_valid_nxt;
    logic [AW-1:0] wr_index_r, wr_index_nxt;
    logic [DW-1:0] wr_data_r, wr_data_nxt;
    logic [DW-1:0] rd_word;                // word at index_r, valid in the same clock as index_r
    logic [7:0]    tx_byte;                // byte chosen for transmission

    assign tx_byte = tx_lo_r ? rd_word[7:0] : rd_word[15:8];

    // next-state logic; bus conditions take priority over bit handling
    always_comb begin
        state_nxt    = state_r;
        phase_nxt    = phase_r;
        bitcnt_nxt   = bitcnt_r;
        shift_nxt    = shift_r;
        is_addr_nxt  = is_addr_r;
        rw_nxt       = rw_r;
        index_nxt    = index_r;
        hi_nxt       = hi_r;
        tx_lo_nxt    = tx_lo_r;
        mack_nxt     = mack_r;
        sda_drv_nxt  = sda_drv_r;
        wr_valid_nxt = 1'b0;
        wr_index_nxt = wr_index_r;
        wr_data_nxt  = wr_data_r;
        if (sel_s) begin
            // three-wire mode selected: stay off the bus
            state_nxt   = ST_IDLE;   // see RULE1
            sda_drv_nxt = 1'b0;
        end else if (start_ev) begin
            // start or repeated start; index is kept for a following read
            state_nxt   = ST_RX;     // see RULE2 see RULE8 see RULE11
            bitcnt_nxt  = 4'h0;
            is_addr_nxt = 1'b1;
            phase_nxt   = PH_INDEX;
            sda_drv_nxt = 1'b0;
        end else if (stop_ev) begin
            state_nxt   = ST_IDLE;   // see RULE7 see RULE8
            sda_drv_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise) begin
                        // msb first, sampled while sclk is high
                        shift_nxt  = {shift_r[6:0], sda_s};   // see RULE3
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end else if (scl_fall && bitcnt_r == `TWCS_BITS_PER_BYTE) begin
                        bitcnt_nxt = 4'h0;
                        if (is_addr_r) begin
                            if (shift_r[7:1] == twcs_own_addr(asel_s)) begin
                                rw_nxt      = shift_r[0];
                                state_nxt   = ST_ACK;   // see RULE4
                                sda_drv_nxt = 1'b1;
                            end else begin
                                state_nxt = ST_WAIT;    // see RULE5
                            end
                        end else begin
                            state_nxt   = ST_ACK;       // see RULE6
                            sda_drv_nxt = 1'b1;
                            case (phase_r)
                                PH_INDEX: begin
                                    index_nxt = shift_r[AW-1:0];   // see RULE10
                                    phase_nxt = PH_HI;
                                end
                                PH_HI: begin
                                    hi_nxt    = shift_r;
                                    phase_nxt = PH_LO;
                                end
                                PH_LO: begin
                                    // full word, hand to the core
                                    wr_valid_nxt = 1'b1;   // see RULE16
                                    wr_index_nxt = index_r;
                                    wr_data_nxt  = {hi_r, shift_r};
                                    if (auto_s) begin
                                        index_nxt = index_r + 7'h01;   // see RULE10
                                        phase_nxt = PH_HI;
                                    end else begin
                                        phase_nxt = PH_DONE;
                                    end
                                end
                                default: begin
                                    // extra byte after a plain write is not acked
                                    state_nxt   = ST_WAIT;
                                    sda_drv_nxt = 1'b0;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    // release on the falling edge that ends the ack clock
                    if (scl_fall) begin
                        sda_drv_nxt = 1'b0;   // see RULE17
                        bitcnt_nxt  = 4'h0;
                        if (is_addr_r && rw_r) begin
                            tx_lo_nxt = 1'b0;
                            state_nxt = ST_LOAD;   // see RULE12
                        end else begin
                            state_nxt = ST_RX;
                        end
                        is_addr_nxt = 1'b0;
                    end
                end
                ST_LOAD: begin
                    // sclk is low here, so driving the first bit is safe
                    shift_nxt   = tx_byte;          // see RULE14
                    sda_drv_nxt = ~tx_byte[7];      // see RULE12 see RULE17
                    bitcnt_nxt  = 4'h0;
                    state_nxt   = ST_TX;
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt_r == `TWCS_BITS_PER_BYTE) begin
                            sda_drv_nxt = 1'b0;   // master owns the ack bit
                            bitcnt_nxt  = 4'h0;
                            state_nxt   = ST_MACK;
                        end else begin
                            shift_nxt   = {shift_r[6:0], 1'b0};
                            sda_drv_nxt = ~shift_r[6];   // see RULE12 see RULE17
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_nxt   = ~sda_s;
                        bitcnt_nxt = 4'h1;
                    end else if (scl_fall && bitcnt_r == 4'h1) begin
                        bitcnt_nxt = 4'h0;
                        if (!mack_r) begin
                            // no ack: master takes the line back
                            state_nxt = ST_WAIT;   // see RULE13
                        end else if (!tx_lo_r) begin
                            tx_lo_nxt = 1'b1;
                            state_nxt = ST_LOAD;
                        end else begin
                            // without auto-increment the same word repeats
                            tx_lo_nxt = 1'b0;
                            state_nxt = ST_LOAD;
                            if (auto_s) begin
                                index_nxt = index_r + 7'h01;   // see RULE15
                            end
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_drv_nxt = 1'b0;   // see RULE5 see RULE17
                end
                default: begin
                    state_nxt   = ST_IDLE;
                    sda_drv_nxt = 1'b0;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= ST_IDLE;
            phase_r    <= PH_INDEX;
            bitcnt_r   <= 4'h0;
            shift_r    <= 8'h00;
            is_addr_r  <= 1'b0;
            rw_r       <= 1'b0;
            index_r    <= '0;
            hi_r       <= 8'h00;
            tx_lo_r    <= 1'b0;
            mack_r     <= 1'b0;
            sda_drv_r  <= 1'b0;
            wr_valid_r <= 1'b0;
            wr_index_r <= '0;
            wr_data_r  <= '0;
        end else begin
            state_r    <= state_nxt;
            phase_r    <= phase_nxt;
            bitcnt_r   <= bitcnt_nxt;
            shift_r    <= shift_nxt;
            is_addr_r  <= is_addr_nxt;
            rw_r       <= rw_nxt;
            index_r    <= index_nxt;
            hi_r       <= hi_nxt;
            tx_lo_r    <= tx_lo_nxt;
            mack_r     <= mack_nxt;
            sda_drv_r  <= sda_drv_nxt;
            wr_valid_r <= wr_valid_nxt;
            wr_index_r <= wr_index_nxt;
            wr_data_r  <= wr_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register store; read address runs one step ahead so data is ready in load

    twcs_regmem #(.AW(AW), .DW(DW), .ID_VALUE(ID_VALUE)) u_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (wr_valid_r),
        .waddr (wr_index_r),
        .wdata (wr_data_r),
        .raddr (index_nxt),
        .rdata (rd_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs; the line is open drain so only the enable ever moves

    logic sda_o_r;        // constant low drive value, kept in a flop
    logic sda_oe_b_r;     // enable in its own flop, no inverter after it on the pin
    logic sda_oe_b_nxt;

    // enable tracks the next drive value, so it moves on the same edge as sda_drv_r
    always_comb begin
        sda_oe_b_nxt = ~sda_drv_nxt;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_o_r    <= 1'b0;
            sda_oe_b_r <= 1'b1;
        end else begin
            sda_o_r    <= 1'b0;
            sda_oe_b_r <= sda_oe_b_nxt;
        end
    end

    assign sda_o        = sda_o_r;
    assign sda_oe_b     = sda_oe_b_r;
    assign reg_wr_valid = wr_valid_r;
    assign reg_wr_index = wr_index_r;
    assign reg_wr_data  = wr_data_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_mode_off;
        @(posedge clk) disable iff (!rst_b)
        sel_s |=> (state_r == ST_IDLE && !sda_drv_r);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("select high left link active"); // see RULE1

    property p_start_rx;
        @(posedge clk) disable iff (!rst_b)
        (start_ev && !sel_s) |=> (state_r == ST_RX && bitcnt_r == 4'h0 && is_addr_r);
    endproperty
    a_start_rx: assert property (p_start_rx) else $error("start not taken"); // see RULE2

    property p_bit_count;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_RX && scl_rise && !sel_s && !start_ev && !stop_ev)
            |=> (bitcnt_r == $past(bitcnt_r) + 4'h1 && shift_r[0] == $past(sda_s));
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit not shifted in"); // see RULE3

    property p_addr_ack;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_RX && is_addr_r && scl_fall && bitcnt_r == 4'h8 && !sel_s
            && shift_r[7:1] == twcs_own_addr(asel_s))
            |=> (state_r == ST_ACK && sda_drv_r);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // see RULE4 see RULE9

    property p_addr_miss;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_RX && is_addr_r && scl_fall && bitcnt_r == 4'h8 && !sel_s
            && shift_r[7:1] != twcs_own_addr(asel_s))
            |=> (state_r == ST_WAIT && !sda_drv_r);
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address not ignored"); // see RULE5

    property p_stop_idle;
        @(posedge clk) disable iff (!rst_b)
        (stop_ev && !sel_s) |=> (state_r == ST_IDLE && !sda_drv_r);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle"); // see RULE7 see RULE8

    property p_wr_pulse;
        @(posedge clk) disable iff (!rst_b)
        wr_valid_r |-> ##1 (!wr_valid_r && $stable(wr_data_r)) ##1 !wr_valid_r;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long"); // see RULE6 see RULE16

    property p_auto_wr;
        @(posedge clk) disable iff (!rst_b)
        (wr_valid_nxt && auto_s && !sel_s) |=> (index_r == $past(index_r) + 7'h01 && phase_r == PH_HI);
    endproperty
    a_auto_wr: assert property (p_auto_wr) else $error("write pointer not advanced"); // see RULE10

    property p_tx_bit;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_TX) |-> (sda_drv_r == ~shift_r[7]);
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("sda not msb of shifter"); // see RULE12

    property p_drive_low_scl;
        @(posedge clk) disable iff (!rst_b)
        $rose(sda_drv_r) |-> !$past(scl_s);
    endproperty
    a_drive_low_scl: assert property (p_drive_low_scl) else $error("sda pulled while sclk high"); // see RULE17

endmodule

`default_nettype wire

// ==== core/twcs_consts.svh ====
`ifndef TWCS_CONSTS_SVH
`define TWCS_CONSTS_SVH

// seven-bit bus address with the address-select pin low (34h written form)
`define TWCS_ADDR_SEL0      7'h1a
// seven-bit bus address with the address-select pin high (36h written form)
`define TWCS_ADDR_SEL1      7'h1b
// bits in one byte on the wire, the ninth clock is the acknowledge
`define TWCS_BITS_PER_BYTE  4'h8
// width of the register index carried in the first data byte
`define TWCS_INDEX_W        7
// width of one control register
`define TWCS_DATA_W         16
// number of stages in a pin synchroniser
`define TWCS_SYNC_STAGES    2
// neutral identity word returned at index zero, value is arbitrary
`define TWCS_ID_VALUE       16'h5a01

`endif

// ==== core/twcs_pkg.sv ====
package twcs_pkg;

    // link-side sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,    // waiting for a start condition
        ST_RX,      // shifting in a byte from the master
        ST_ACK,     // holding sda low for the acknowledge clock
        ST_LOAD,    // one clock to fetch the byte to transmit
        ST_TX,      // shifting a read byte out
        ST_MACK,    // sampling the master acknowledge
        ST_WAIT     // ignoring the bus until start or stop
    } twcs_state_t;

    // position within a three-byte write
    typedef enum logic [1:0] {
        PH_INDEX,   // next byte is the register index
        PH_HI,      // next byte is the upper data byte
        PH_LO,      // next byte is the lower data byte
        PH_DONE     // sequence complete, further bytes refused
    } twcs_phase_t;

endpackage

// ==== core/twcs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// plain two-flop synchroniser for slow pins, one bit per lane
module twcs_sync #(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;   // first stage, read only by the second
    logic [W-1:0] sync_r;   // second stage
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    // next values: straight shift through the two stages
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // both stages reset high like an idle bus, so no false edge follows reset;
    // a select pin that reads high for two clocks only holds the link idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule

`default_nettype wire

// ==== core/twcs_regmem.sv ====
`include "twcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// control register store: one write port, one registered read port
module twcs_regmem #(
    parameter int          AW       = `TWCS_INDEX_W,
    parameter int          DW       = `TWCS_DATA_W,
    parameter logic [15:0] ID_VALUE = `TWCS_ID_VALUE   // arbitrary identity word
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];   // no reset, contents come from writes
    logic [DW-1:0] rdata_r;             // registered read word
    logic [DW-1:0] rdata_nxt;

    // index zero always answers with the identity word
    always_comb begin
        if (raddr == '0) begin
            rdata_nxt = DW'(ID_VALUE);
        end else begin
            rdata_nxt = mem[raddr];
        end
    end

    // array write, kept free of reset so it maps onto ram
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule

`default_nettype wire

// ==== bench/twcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// bus master model: scl idles high, sda goes to the pull-up when released
module twcs_host (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // wait n core clocks, every change lands just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic start();
        tick(1);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // stop: sda rises while scl is high, clock then stands still
    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
    endtask
    // nine clocks: d msb first, m is the ninth bit (1 = released)
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        logic [8:0] s;
        s = {d, m};
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            sda_low <= ~s[i];
            tick(3);
            scl <= 1'b1;
            tick(4);
            if (i > 0) q[i-1] = sda_line;
            else a = sda_line;
            scl <= 1'b0;
        end
        tick(1);
        sda_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_twcs_slave.sv ====
`include "twcs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_twcs_slave;
    logic        clk, rst_b, interface_select_pin, addr_select_pin, auto_inc_en;
    logic        scl, sda_low, sda_o, sda_oe_b, reg_wr_valid, a;
    logic [6:0]  reg_wr_index, k;
    logic [15:0] reg_wr_data, d0, d1;
    logic [7:0]  q;
    logic [22:0] exp_q[$];
    logic [31:0] seed;
    int          bad_count, tests_run;
    // wired-and line with pull-up
    wire         sda_line = ~sda_low & (sda_oe_b | sda_o);
    always #20 clk = ~clk;
    twcs_slave dut (.clk(clk), .rst_b(rst_b), .interface_select_pin(interface_select_pin),
        .addr_select_pin(addr_select_pin), .auto_inc_en(auto_inc_en), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_b(sda_oe_b), .reg_wr_valid(reg_wr_valid), .reg_wr_index(reg_wr_index),
        .reg_wr_data(reg_wr_data));
    twcs_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [22:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one byte from the master, ack_exp 0 means the device must pull low
    task automatic wr(input logic [7:0] d, input logic ack_exp);
        host.xfer(d, 1'b1, q, a);
        check("ack", a, ack_exp);
    endtask
    // address, index, n words; x adds a byte that must be refused
    task automatic write(input logic [6:0] dev, idx, input logic [15:0] w0, w1, input int n, input logic ok, x);
        host.start();
        wr({dev, 1'b0}, ~ok);
        wr({1'b0, idx}, ~ok);
        for (int i = 0; i < n; i++) begin
            wr(i ? w1[15:8] : w0[15:8], ~ok);
            if (ok) exp_q.push_back({idx + i[6:0], i ? w1 : w0});
            wr(i ? w1[7:0] : w0[7:0], ~ok);
        end
        if (x) wr(8'h5a, 1'b1);
        host.stop();
    endtask
    // index write, repeated start, n words read, last byte not acked
    task automatic read(input logic [6:0] dev, idx, input logic [15:0] e0, e1, input int n);
        logic [7:0] h;
        host.start();
        wr({dev, 1'b0}, 1'b0);
        wr({1'b0, idx}, 1'b0);
        host.start();
        wr({dev, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hff, 1'b0, h, a);
            host.xfer(8'hff, i == n - 1, q, a);
            check("read", {7'h0, h, q}, {7'h0, i ? e1 : e0});
        end
        host.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    // every write pulse must match the oldest note
    always @(negedge clk) begin
        if (reg_wr_valid === 1'b1) begin
            if (exp_q.size() == 0) check("stray write", 23'h1, 23'h0);
            else check("write", {reg_wr_index, reg_wr_data}, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        interface_select_pin = 1'b0;
        addr_select_pin = 1'b0;
        auto_inc_en = 1'b0;
        seed = 32'hf9152c63;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        for (int s = 0; s < 2; s++) begin
            addr_select_pin <= s[0];
            d0 = 16'(rnd());
            d1 = 16'(rnd());
            k = 7'(1 + rnd() % 120);
            write(s ? 7'h1b : 7'h1a, k, d0, d1, 1, 1'b1, 1'b1);
            read(s ? 7'h1b : 7'h1a, k, d0, d0, 2);
            write(s ? 7'h1a : 7'h1b, k, d1, d1, 1, 1'b0, 1'b1);
            // transfer cut short by a stop before the lower byte
            host.start();
            wr({s ? 7'h1b : 7'h1a, 1'b0}, 1'b0);
            wr({1'b0, k}, 1'b0);
            wr(d1[15:8], 1'b0);
            host.stop();
            read(s ? 7'h1b : 7'h1a, k, d0, d0, 1);
        end
        auto_inc_en <= 1'b1;
        write(7'h1b, k, d0, d1, 2, 1'b1, 1'b0);
        read(7'h1b, k, d0, d1, 2);
        interface_select_pin <= 1'b1;
        write(7'h1b, k, d1, d1, 1, 1'b0, 1'b0);
        interface_select_pin <= 1'b0;
        read(7'h1b, k, d0, d1, 2);
        // index zero answers with the identity word
        read(7'h1b, 7'h00, `TWCS_ID_VALUE, `TWCS_ID_VALUE, 1);
        check("pending", 23'(exp_q.size()), 23'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
